/* pkg/lbert_pkg.sv */
// constants and types shared by the bit error rate tester and its host controller
// assumes one clock (hclk) and an asynchronous active-low reset on both ends
`default_nettype none
package lbert_pkg;
   // tester register indices (one byte each)
   localparam int REG_AW = 5;
   localparam int NUM_REGS = 24;
   localparam logic [4:0] REG_CONTROL_ONE = 5'h00;
   localparam logic [4:0] REG_INTERFACE_CONTROL = 5'h01;
   localparam logic [4:0] REG_EVENT_INFO = 5'h02;
   localparam logic [4:0] REG_STATUS_NINE = 5'h03;
   localparam logic [4:0] REG_PATTERN_BYTE_ONE = 5'h04;
   localparam logic [4:0] REG_BIT_COUNT_BYTE_ONE = 5'h08;
   localparam logic [4:0] REG_ERROR_COUNT_BYTE_ONE = 5'h0c;
   localparam logic [4:0] REG_ALT_WORD_COUNT = 5'h0f;
   localparam logic [4:0] REG_TX_SLOT_SELECT = 5'h10;
   localparam logic [4:0] REG_RX_SLOT_SELECT = 5'h14;
   // tester_control_one fields
   localparam int C1_MODE_LSB = 0;
   localparam int C1_LOAD_CLEAR = 3;
   localparam int C1_MASK_SYNC = 4;
   localparam int C1_MASK_ERR = 5;
   localparam int C1_MASK_OVF = 6;
   // tester_interface_control fields
   localparam int IC_ENABLE = 0;
   localparam int IC_DIRECTION = 1;
   localparam int IC_RX_FBIT = 2;
   localparam int IC_TX_FBIT = 3;
   // tester_event_info fields
   localparam int INFO_SYNC = 0;
   localparam int INFO_SYNC_CHG = 1;
   localparam int INFO_BIT_ERR = 2;
   localparam int INFO_BCO = 3;
   localparam int INFO_ECO = 4;
   // port_status_nine fields
   localparam int SR9_SYNC_CHG = 0;
   localparam int SR9_BIT_ERR = 1;
   localparam int SR9_OVF = 2;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_PATTERN_BYTE = 8'hff;
   // receive synchroniser
   localparam logic [5:0] SYNC_GOOD_BITS = 6'h20;
   localparam logic [2:0] SYNC_LOSS_ERRS = 3'h6;
   localparam logic [3:0] QRSS_MAX_ZEROS = 4'he;
   typedef enum logic [2:0] {
      MODE_PRBS7, MODE_PRBS11, MODE_PRBS15, MODE_QRSS, MODE_REPEAT, MODE_ALT_WORD, MODE_DALY
   } lbert_mode_t;
   typedef struct packed {
      logic [19:0] lfsr;
      logic [4:0] pos;
      logic [7:0] rep;
      logic wsel;
      logic [3:0] zrun;
   } lbert_gen_t;
   // host controller registers on AHB-Lite
   localparam logic [7:0] AHB_CMD = 8'h00;
   localparam logic [7:0] AHB_STATUS = 8'h04;
   localparam int CMD_DATA_LSB = 0;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_WRITE = 16;
   localparam int CMD_W = 17;
   typedef enum logic {HOST_IDLE, HOST_WAIT} lbert_host_state_t;
endpackage
`default_nettype wire

/* pkg/lbert_link_if.sv */
// byte register port between host controller and tester, plus the event level
// assumes both ends share hclk and hresetn
`default_nettype none
interface lbert_link_if (
   input wire logic hclk,
   input wire logic hresetn
);
   logic req;
   logic write;
   logic [lbert_pkg::REG_AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   logic event_flag;
   modport tester (input hclk, hresetn, req, write, addr, wdata, output rdata, ack, event_flag);
   modport host (input hclk, hresetn, rdata, ack, event_flag, output req, write, addr, wdata);
endinterface
`default_nettype wire

/* design/lbert_tester.sv */
// bit error rate tester: pattern generator, checker, counters and byte registers
// assumes bit strobes, slot numbers and f-bit flags are synchronous to hclk
// Overview of operation
// - generate/check prbs 2e7, 2e11, 2e15, qrss, daly
// - repeating user pattern up to 32 bits
// - two 16-bit words alternate after 1..256 repeats
// - events: sync change, bit error, counter overflow
// - each event type maskable in control one
// - host reads event info after an event
// - host enables interface mux before use
// - status nine latches tester changes of state
// - latched bits set on event, clear on read
// - direction bit picks network or backplane side
// - slot select bits limit insertion and checking
// - t1 f-bit included by separate rx/tx enables
// - host replicates short pattern, lsb sent first
// - host loads all ones for pseudorandom modes
// - host loads words into byte pairs
// - each word repeats alternating-count times
// - synced: 32-bit counter counts every received bit
// - synced: 24-bit counter counts mismatching bits
// - counter-load-clear bit clears both counters
// - bit counter saturates, sets its overflow flag
// - error counter saturates, sets its overflow flag
`default_nettype none
module lbert_tester #(
   parameter logic [31:0] DALY_WORD = 32'h0000_0001,
   parameter int NUM_SLOTS = 32
) (
   lbert_link_if.tester link,
   input wire logic [1:0] tx_strobe,
   input wire logic [1:0][4:0] tx_slot,
   input wire logic [1:0] tx_fbit,
   input wire logic [1:0] tx_in,
   output logic [1:0] tx_out,
   input wire logic [1:0] rx_strobe,
   input wire logic [1:0][4:0] rx_slot,
   input wire logic [1:0] rx_fbit,
   input wire logic [1:0] rx_in,
   output logic in_sync
);
   import lbert_pkg::*;

   if (NUM_SLOTS < 24 || NUM_SLOTS > 32) begin : g_bad_slots
      $error("NUM_SLOTS must lie between 24 and 32");
   end

   logic [7:0] control_one;
   logic [7:0] interface_control;
   logic [7:0] alternating_word_count;
   logic [7:0] pattern_byte [4];
   logic [7:0] tx_sel_byte [4];
   logic [7:0] rx_sel_byte [4];
   logic [4:1] event_info;
   logic [2:0] port_status_nine;
   logic [31:0] bit_cnt;
   logic [23:0] err_cnt;
   logic lc_prev;
   logic sync_d;
   logic [5:0] good_run;
   logic [2:0] bad_cnt;
   lbert_gen_t tx_gen;
   lbert_gen_t rx_gen;
   logic [7:0] rmap [NUM_REGS];

   function automatic logic gen_fb(lbert_gen_t g, lbert_mode_t m);
      case (m)
         MODE_PRBS7: gen_fb = g.lfsr[6] ^ g.lfsr[5];
         MODE_PRBS11: gen_fb = g.lfsr[10] ^ g.lfsr[8];
         MODE_PRBS15: gen_fb = g.lfsr[14] ^ g.lfsr[13];
         MODE_QRSS: gen_fb = g.lfsr[19] ^ g.lfsr[16];
         default: gen_fb = 1'b0;
      endcase
   endfunction

   function automatic logic gen_bit(lbert_gen_t g, lbert_mode_t m, logic [31:0] p);
      case (m)
         MODE_PRBS7, MODE_PRBS11, MODE_PRBS15: gen_bit = gen_fb(g, m);
         MODE_QRSS: gen_bit = gen_fb(g, m) | (g.zrun == QRSS_MAX_ZEROS);
         MODE_ALT_WORD: gen_bit = p[{g.wsel, g.pos[3:0]}];
         MODE_DALY: gen_bit = DALY_WORD[g.pos];
         default: gen_bit = p[g.pos];
      endcase
   endfunction

   function automatic lbert_gen_t gen_next(lbert_gen_t g, lbert_mode_t m, logic [7:0] awc,
                                           logic sin, logic ob);
      lbert_gen_t n;
      n = g;
      n.lfsr = {g.lfsr[18:0], sin};
      n.zrun = ob ? 4'h0 : ((g.zrun == 4'hf) ? g.zrun : g.zrun + 4'h1);
      n.pos = g.pos + 5'h01;
      if (m == MODE_ALT_WORD && g.pos[3:0] == 4'hf) begin
         n.pos = 5'h00;
         // a count of zero wraps to 256 repeats
         if (g.rep == awc - 8'h01) begin
            n.rep = 8'h00;
            n.wsel = ~g.wsel;
         end else begin
            n.rep = g.rep + 8'h01;
         end
      end
      return n;
   endfunction

   // decode
   wire lbert_mode_t mode = lbert_mode_t'(control_one[C1_MODE_LSB +: 3]);
   wire is_prbs = (mode <= MODE_QRSS);
   wire enable = interface_control[IC_ENABLE];
   wire dir = interface_control[IC_DIRECTION];
   wire [31:0] pattern = {pattern_byte[3], pattern_byte[2], pattern_byte[1], pattern_byte[0]};
   wire [31:0] tx_sel = {tx_sel_byte[3], tx_sel_byte[2], tx_sel_byte[1], tx_sel_byte[0]};
   wire [31:0] rx_sel = {rx_sel_byte[3], rx_sel_byte[2], rx_sel_byte[1], rx_sel_byte[0]};
   wire wr = link.req & link.write;
   wire rd = link.req & ~link.write;
   wire c1_wr = wr && link.addr == REG_CONTROL_ONE;
   wire pat_wr = wr && ((link.addr >= REG_PATTERN_BYTE_ONE && link.addr < REG_BIT_COUNT_BYTE_ONE)
                        || link.addr == REG_ALT_WORD_COUNT);
   // a new pattern or mode restarts both ends so the checker never compares stale state
   wire reseed = ~enable | pat_wr | (c1_wr && link.wdata[2:0] != control_one[2:0]);
   wire lbert_gen_t seed = '{lfsr: pattern[19:0], default: '0};

   wire tx_hit = enable & tx_strobe[dir]
      & (tx_fbit[dir] ? interface_control[IC_TX_FBIT] : tx_sel[tx_slot[dir]]);
   wire rx_hit = enable & rx_strobe[dir]
      & (rx_fbit[dir] ? interface_control[IC_RX_FBIT] : rx_sel[rx_slot[dir]]);
   wire tx_bit = gen_bit(tx_gen, mode, pattern);
   wire exp_bit = gen_bit(rx_gen, mode, pattern);
   wire rx_bit = rx_in[dir];
   wire mism = rx_bit ^ exp_bit;
   wire bit_inc = rx_hit & in_sync;
   wire err_inc = bit_inc & mism;
   wire lc_rise = control_one[C1_LOAD_CLEAR] & ~lc_prev;
   wire bco_evt = bit_inc && bit_cnt == 32'hffff_fffe;
   wire eco_evt = err_inc && err_cnt == 24'hff_fffe;
   wire chg_evt = in_sync ^ sync_d;
   wire [4:1] info_evt = {eco_evt, bco_evt, err_inc, chg_evt};
   wire [2:0] sr9_evt = {eco_evt | bco_evt, err_inc, chg_evt};
   wire clr_info = rd && link.addr == REG_EVENT_INFO;
   wire clr_sr9 = rd && link.addr == REG_STATUS_NINE;
   wire [2:0] ev_mask = {control_one[C1_MASK_OVF], control_one[C1_MASK_ERR],
                         control_one[C1_MASK_SYNC]};
   wire [2:0] ev_live = {event_info[INFO_BCO] | event_info[INFO_ECO],
                         event_info[INFO_BIT_ERR], event_info[INFO_SYNC_CHG]};
   wire [7:0] rd_mux = (link.addr < REG_AW'(NUM_REGS)) ? rmap[link.addr] : RST_BYTE;

   assign link.event_flag = |(ev_live & ~ev_mask);

   // read map
   assign rmap[REG_CONTROL_ONE] = control_one;
   assign rmap[REG_INTERFACE_CONTROL] = interface_control;
   assign rmap[REG_EVENT_INFO] = {3'h0, event_info, in_sync};
   assign rmap[REG_STATUS_NINE] = {5'h00, port_status_nine};
   assign rmap[REG_ALT_WORD_COUNT] = alternating_word_count;
   for (genvar i = 0; i < 4; i++) begin : g_bytes
      assign rmap[REG_PATTERN_BYTE_ONE + i] = pattern_byte[i];
      assign rmap[REG_BIT_COUNT_BYTE_ONE + i] = bit_cnt[8*i +: 8];
      assign rmap[REG_TX_SLOT_SELECT + i] = tx_sel_byte[i];
      assign rmap[REG_RX_SLOT_SELECT + i] = rx_sel_byte[i];
      if (i < 3) begin : g_err
         assign rmap[REG_ERROR_COUNT_BYTE_ONE + i] = err_cnt[8*i +: 8];
      end
      always_ff @(posedge link.hclk or negedge link.hresetn) begin
         if (!link.hresetn) begin
            pattern_byte[i] <= RST_PATTERN_BYTE;
            tx_sel_byte[i] <= RST_BYTE;
            rx_sel_byte[i] <= RST_BYTE;
         end else if (wr) begin
            if (link.addr == REG_AW'(REG_PATTERN_BYTE_ONE + i)) pattern_byte[i] <= link.wdata;
            if (link.addr == REG_AW'(REG_TX_SLOT_SELECT + i)) tx_sel_byte[i] <= link.wdata;
            if (link.addr == REG_AW'(REG_RX_SLOT_SELECT + i)) rx_sel_byte[i] <= link.wdata;
         end
      end
   end

   // control registers and bus answer, one cycle after the request
   always_ff @(posedge link.hclk or negedge link.hresetn) begin
      if (!link.hresetn) begin
         control_one <= RST_BYTE;
         interface_control <= RST_BYTE;
         alternating_word_count <= RST_BYTE;
         link.ack <= 1'b0;
         link.rdata <= RST_BYTE;
      end else begin
         link.ack <= link.req;
         if (rd) link.rdata <= rd_mux;
         if (c1_wr) control_one <= link.wdata;
         if (wr && link.addr == REG_INTERFACE_CONTROL) interface_control <= link.wdata;
         if (wr && link.addr == REG_ALT_WORD_COUNT) alternating_word_count <= link.wdata;
      end
   end

   // latched flags: a new event wins over the read that clears
   always_ff @(posedge link.hclk or negedge link.hresetn) begin
      if (!link.hresetn) begin
         event_info <= '0;
         port_status_nine <= '0;
         sync_d <= 1'b0;
      end else begin
         sync_d <= in_sync;
         event_info <= (clr_info ? 4'h0 : event_info) | info_evt;
         port_status_nine <= (clr_sr9 ? 3'h0 : port_status_nine) | sr9_evt;
      end
   end

   // counters
   always_ff @(posedge link.hclk or negedge link.hresetn) begin
      if (!link.hresetn) begin
         lc_prev <= 1'b0;
         bit_cnt <= '0;
         err_cnt <= '0;
      end else begin
         lc_prev <= control_one[C1_LOAD_CLEAR];
         if (lc_rise) begin
            bit_cnt <= '0;
            err_cnt <= '0;
         end else begin
            if (bit_inc && bit_cnt != 32'hffff_ffff) bit_cnt <= bit_cnt + 32'h1;
            if (err_inc && err_cnt != 24'hff_ffff) err_cnt <= err_cnt + 24'h1;
         end
      end
   end

   // generator; the chosen side gets pattern bits, the other passes through
   always_ff @(posedge link.hclk or negedge link.hresetn) begin
      if (!link.hresetn) tx_gen <= '0;
      else if (reseed) tx_gen <= seed;
      else if (tx_hit) tx_gen <= gen_next(tx_gen, mode, alternating_word_count,
                                          gen_fb(tx_gen, mode), tx_bit);
   end
   for (genvar s = 0; s < 2; s++) begin : g_side
      always_ff @(posedge link.hclk or negedge link.hresetn) begin
         if (!link.hresetn) tx_out[s] <= 1'b0;
         else if (tx_strobe[s]) tx_out[s] <= (tx_hit && dir == s) ? tx_bit : tx_in[s];
      end
   end

   // checker: prbs modes self-synchronise by loading received bits, fixed ones slip a bit
   always_ff @(posedge link.hclk or negedge link.hresetn) begin
      if (!link.hresetn) begin
         rx_gen <= '0;
         in_sync <= 1'b0;
         good_run <= '0;
         bad_cnt <= '0;
      end else if (reseed) begin
         rx_gen <= seed;
         in_sync <= 1'b0;
         good_run <= '0;
         bad_cnt <= '0;
      end else if (rx_hit) begin
         if (!in_sync && is_prbs) rx_gen <= gen_next(rx_gen, mode, alternating_word_count,
                                                     rx_bit, rx_bit);
         else if (in_sync || !mism) rx_gen <= gen_next(rx_gen, mode, alternating_word_count,
                                                        gen_fb(rx_gen, mode), exp_bit);
         if (mism) begin
            good_run <= '0;
            if (in_sync) begin
               bad_cnt <= bad_cnt + 3'h1;
               if (bad_cnt == SYNC_LOSS_ERRS - 3'h1) begin
                  in_sync <= 1'b0;
                  bad_cnt <= '0;
               end
            end
         end else if (good_run != SYNC_GOOD_BITS) begin
            good_run <= good_run + 6'h01;
            if (good_run == SYNC_GOOD_BITS - 6'h01) begin
               in_sync <= 1'b1;
               bad_cnt <= '0;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* design/lbert_host.sv */
// host controller: AHB-Lite slave that forwards byte commands to the tester
// assumes a single AHB-Lite master; every transfer completes with no wait state
`default_nettype none
module lbert_host (
   lbert_link_if.host link,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   import lbert_pkg::*;

   lbert_host_state_t state;
   logic [CMD_W-1:0] cmd;
   logic cmd_pend;
   logic auto_rd;
   logic a_wr;
   logic [7:0] a_off;
   logic [7:0] rdata_last;
   logic [7:0] info_cap;

   wire take = hsel & hready & htrans[1];
   wire busy = cmd_pend | (state == HOST_WAIT);
   wire cmd_wr = a_wr && a_off == AHB_CMD && !busy;
   wire [31:0] status_word = {8'h00, info_cap, 6'h00, link.event_flag, busy, rdata_last};
   wire [31:0] read_mux = (haddr[7:0] == AHB_CMD) ? {{(32 - CMD_W){1'b0}}, cmd} :
                          (haddr[7:0] == AHB_STATUS) ? status_word : 32'h0000_0000;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // hsize is always a word here, so it is not decoded
   always_ff @(posedge link.hclk or negedge link.hresetn) begin
      if (!link.hresetn) begin
         a_wr <= 1'b0;
         a_off <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         a_wr <= take & hwrite;
         if (take) a_off <= haddr[7:0];
         if (take && !hwrite) hrdata <= read_mux;
      end
   end

   // a command written while busy is dropped; software polls busy first
   always_ff @(posedge link.hclk or negedge link.hresetn) begin
      if (!link.hresetn) begin
         state <= HOST_IDLE;
         cmd <= '0;
         cmd_pend <= 1'b0;
         auto_rd <= 1'b0;
         rdata_last <= 8'h00;
         info_cap <= 8'h00;
         link.req <= 1'b0;
         link.write <= 1'b0;
         link.addr <= '0;
         link.wdata <= 8'h00;
      end else begin
         if (cmd_wr) begin
            cmd <= hwdata[CMD_W-1:0];
            cmd_pend <= 1'b1;
         end
         case (state)
            HOST_IDLE: begin
               if (cmd_pend) begin
                  link.req <= 1'b1;
                  link.write <= cmd[CMD_WRITE];
                  link.addr <= cmd[CMD_ADDR_LSB +: REG_AW];
                  link.wdata <= cmd[CMD_DATA_LSB +: 8];
                  cmd_pend <= 1'b0;
                  auto_rd <= 1'b0;
                  state <= HOST_WAIT;
               end else if (link.event_flag) begin
                  link.req <= 1'b1;
                  link.write <= 1'b0;
                  link.addr <= REG_EVENT_INFO;
                  auto_rd <= 1'b1;
                  state <= HOST_WAIT;
               end
            end
            HOST_WAIT: begin
               link.req <= 1'b0;
               if (link.ack) begin
                  if (auto_rd) info_cap <= link.rdata;
                  else if (!link.write) rdata_last <= link.rdata;
                  state <= HOST_IDLE;
               end
            end
            default: state <= HOST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* dv/lbert_checker.sv */
// link checker: handshake, event service, masking and register readback
// assumes one hclk domain; hresetn asynchronous, active low
`default_nettype none
module lbert_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic req,
   input wire logic write,
   input wire logic [lbert_pkg::REG_AW-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic event_flag
);
   import lbert_pkg::*;
   logic [7:0] shadow [0:23];
   logic [4:0] ra, wait_cnt;
   logic [7:0] rv;
   logic rw, masked;
   wire info_rd = req && !write && addr == REG_EVENT_INFO;
   wire rw_reg = ra inside {[5'd4:5'd7], [5'd15:5'd23]};
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // request fields kept until the ack, since the host may move addr after req
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ra <= '0;
         rw <= 1'b0;
         rv <= '0;
         masked <= 1'b0;
         wait_cnt <= '0;
         for (int i = 0; i < 24; i++) begin
            shadow[i] <= (i >= 4 && i < 8) ? RST_PATTERN_BYTE : RST_BYTE;
         end
      end else begin
         if (req) begin
            ra <= addr;
            rw <= write;
            rv <= wdata;
         end
         if (ack && rw && rw_reg) begin
            shadow[ra] <= rv;
         end
         // follow the mask write at the edge the tester takes it, not at the later ack
         if (req && write && addr == REG_CONTROL_ONE) begin
            masked <= &wdata[C1_MASK_OVF:C1_MASK_SYNC];
         end
         wait_cnt <= (event_flag && !info_rd) ? wait_cnt + 5'd1 : 5'd0;
      end
   end
   ack_follows_a: assert property (req |=> ack)
      else $error("ack missing after req");
   ack_cause_a: assert property (ack |-> $past(req))
      else $error("ack without req");
   req_gap_a: assert property (req |=> !req)
      else $error("requests too close");
   event_serve_a: assert property (wait_cnt < 5'd24)
      else $error("event left unread");
   mask_all_a: assert property (masked |-> !event_flag)
      else $error("masked event raised flag");
   rdata_hold_a: assert property (!(ack && !rw) |-> $stable(rdata))
      else $error("read data moved");
   unmapped_zero_a: assert property (ack && !rw && ra > 5'd23 |-> rdata == 8'h00)
      else $error("unmapped index not zero");
   reg_readback_a: assert property (ack && !rw && rw_reg |-> rdata == shadow[ra])
      else $error("register readback mismatch");
endmodule
`default_nettype wire

/* dv/tb_line_bit_error_rate_tester.sv */
// bench: AHB-Lite master commands the tester through the host; streams looped back
// assumes host and tester share hclk; one bit every fourth cycle
`default_nettype none
module tb_line_bit_error_rate_tester;
   timeunit 1ns;
   timeprecision 1ps;
   import lbert_pkg::*;
   localparam logic [31:0] DALY = 32'h0f3c_00a5; // arbitrary stand-in word
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, st, seed = 32'h4c27;
   logic [1:0] htrans = '0, txs = '0, rxs = '0, txi = '0, rxi = '0, txo, ph = '0;
   logic [2:0] hsize = 3'h2, fl = '0;
   logic hreadyout, hresp, in_sync, dir = 1'b0, col = 1'b0, fb = 1'b0;
   logic [4:0] slot = '0;
   logic [19:0] left = '0;
   logic q[$];
   int errors = 0, total_checks = 0, cyc = 0;
   int pers [7] = '{127, 2047, 0, 0, 8, 64, 32};
   int ones [7] = '{64, 1024, 0, 0, 4, 24, 12};
   wire flip = fl != 3'd0 && left[3:0] == 4'h8;
   always #4 hclk = ~hclk;
   lbert_link_if link (.hclk(hclk), .hresetn(hresetn));
   lbert_host u_lbert_host (.link(link.host), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   lbert_tester #(.DALY_WORD(DALY)) u_lbert_tester (.link(link.tester), .tx_strobe(txs),
      .tx_slot({slot, slot}), .tx_fbit({fb, fb}), .tx_in(txi), .tx_out(txo), .rx_strobe(rxs),
      .rx_slot({slot, slot}), .rx_fbit({fb, fb}), .rx_in(rxi), .in_sync(in_sync));
   lbert_checker u_lbert_checker (.hclk(hclk), .hresetn(hresetn), .req(link.req),
      .write(link.write), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
      .ack(link.ack), .event_flag(link.event_flag));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] rst_val(input int i);
      return (i >= 4 && i < 8) ? RST_PATTERN_BYTE : RST_BYTE;
   endfunction
   // short pattern replicated over 32 bits, first word in bytes one and two
   function automatic logic [7:0] pat(input int m, input int k);
      logic [31:0] w;
      w = (m == 4) ? 32'h2d2d_2d2d : (m == 5) ? 32'h7e7e_0000 : 32'hffff_ffff;
      return w[8*k +: 8];
   endfunction
   // tx taken at phase 1, echoed to rx at phase 2, checked at phase 3
   always @(posedge hclk) begin
      ph <= (left != 0) ? ph + 2'd1 : 2'd0;
      txs <= {2{left != 0 && ph == 2'd0}};
      rxs <= {2{left != 0 && ph == 2'd2}};
      if (left != 0 && ph == 2'd2) begin
         rxi <= txo ^ {2{flip}};
         if (col) q.push_back(txo[dir]);
         chk(txo[~dir], txi[~dir]);
      end
      if (left != 0 && ph == 2'd3) begin
         left <= left - 20'd1;
         fl <= flip ? fl - 3'd1 : fl;
         slot <= (left[2:0] == 3'd1) ? slot + 5'd1 : slot;
         txi <= 2'(rnd());
      end
   end
   always @(posedge hclk) begin
      if (cyc == 90000) begin
         errors++;
         give_verdict();
      end else cyc <= cyc + 1;
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk(hresp, 1'b0);
   endtask
   // busy is polled first too: a command written while busy is dropped
   task automatic cmd(input logic w, input logic [4:0] i, input logic [7:0] d,
      output logic [7:0] r);
      do ahb(1'b0, AHB_STATUS, '0, st); while (st[8] !== 1'b0);
      ahb(1'b1, AHB_CMD, {15'h0, w, 3'h0, i, d}, st);
      do ahb(1'b0, AHB_STATUS, '0, st); while (st[8] !== 1'b0);
      r = st[7:0];
   endtask
   task automatic wr(input logic [4:0] i, input logic [7:0] d);
      logic [7:0] x;
      cmd(1'b1, i, d, x);
   endtask
   task automatic cnt(input logic [4:0] i, input int n, output logic [31:0] c);
      logic [7:0] b;
      c = '0;
      for (int k = 0; k < n; k++) begin
         cmd(1'b0, i + 5'(k), 8'h0, b);
         c[8*k +: 8] = b;
      end
   endtask
   task automatic run(input logic [19:0] n, input logic [2:0] f);
      left <= n;
      fl <= f;
      @(posedge hclk);
      while (left != 0) @(posedge hclk);
      repeat (4) @(posedge hclk);
   endtask
   // a periodic stream repeats after p bits and holds a fixed count of ones
   task automatic per(input int p, input int n1);
      int bad = 0;
      int o = 0;
      for (int n = p; n < q.size(); n++) if (q[n] !== q[n-p]) bad++;
      for (int n = 0; n < p; n++) if (q[n] === 1'b1) o++;
      chk(bad, 0);
      chk(o, n1);
   endtask
   initial begin
      logic [7:0] b;
      logic [31:0] c, v;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 32; i++) begin
         cmd(1'b0, 5'(i), 8'h0, b);
         chk(b, rst_val(i));
      end
      ahb(1'b0, 8'h08, '0, c);
      chk(c, 32'h0);
      for (int i = 15; i < 24; i++) begin
         v = rnd();
         wr(5'(i), v[7:0]);
         cmd(1'b0, 5'(i), 8'h0, b);
         chk(b, v[7:0]);
      end
      for (int i = 16; i < 24; i++) wr(5'(i), 8'hff);
      for (int m = 0; m < 7; m++) begin
         dir <= m == 6;
         for (int k = 0; k < 4; k++) wr(REG_PATTERN_BYTE_ONE + 5'(k), pat(m, k));
         wr(REG_ALT_WORD_COUNT, 8'h02);
         wr(REG_INTERFACE_CONTROL, {6'h0, m == 6, 1'b1});
         wr(REG_CONTROL_ONE, 8'(m));
         q.delete();
         col <= 1'b1;
         run(20'(pers[m] * 2 + 200), 3'd0);
         col <= 1'b0;
         chk(in_sync, 1'b1);
         if (pers[m] != 0) per(pers[m], ones[m]);
      end
      wr(REG_CONTROL_ONE, 8'h0e);
      cnt(REG_BIT_COUNT_BYTE_ONE, 4, c);
      chk(c, 0);
      run(20'd100, 3'd0);
      cnt(REG_BIT_COUNT_BYTE_ONE, 4, c);
      chk(c, 100);
      run(20'd100, 3'd3);
      cnt(REG_BIT_COUNT_BYTE_ONE, 4, c);
      chk(c, 200);
      cnt(REG_ERROR_COUNT_BYTE_ONE, 3, c);
      chk(c, 3);
      ahb(1'b0, AHB_STATUS, '0, st);
      chk(st[16 + INFO_BIT_ERR], 1'b1);
      cmd(1'b0, REG_STATUS_NINE, 8'h0, b);
      chk(b[SR9_BIT_ERR], 1'b1);
      cmd(1'b0, REG_STATUS_NINE, 8'h0, b);
      chk(b, 8'h00);
      wr(REG_CONTROL_ONE, 8'h0e);
      cnt(REG_BIT_COUNT_BYTE_ONE, 4, c);
      chk(c, 200);
      wr(REG_CONTROL_ONE, 8'h06);
      wr(REG_CONTROL_ONE, 8'h0e);
      cnt(REG_BIT_COUNT_BYTE_ONE, 4, c);
      chk(c, 0);
      wr(REG_CONTROL_ONE, 8'h7e);
      run(20'd100, 3'd1);
      ahb(1'b0, AHB_STATUS, '0, st);
      chk(st[9], 1'b0);
      cnt(REG_ERROR_COUNT_BYTE_ONE, 3, c);
      chk(c, 1);
      // both ends deselected, so they stay in step for the f-bit run below
      for (int i = 16; i < 24; i++) wr(5'(i), 8'h00);
      cnt(REG_BIT_COUNT_BYTE_ONE, 4, v);
      run(20'd50, 3'd0);
      cnt(REG_BIT_COUNT_BYTE_ONE, 4, c);
      chk(c, v);
      fb <= 1'b1;
      wr(REG_INTERFACE_CONTROL, 8'h0f);
      run(20'd50, 3'd0);
      cnt(REG_BIT_COUNT_BYTE_ONE, 4, c);
      chk(c, v + 32'd50);
      give_verdict();
   end
endmodule
`default_nettype wire
